/* File: core/pd_seq_pkg.sv */
// Shared constants and types of the PD source timing sequencer.
// Assumes a 100 MHz pclk and a one millisecond internal tick.
package pd_seq_pkg;

	localparam int CLK_MHZ   = 100;
	localparam int MS_CYCLES = 1000 * CLK_MHZ;
	localparam int TW        = 13;

	// Millisecond intervals, figure in ms (4.8 s given as 4800 ms)
	localparam logic [TW-1:0] ARM_MS      = 13'h00BE; // 190
	localparam logic [TW-1:0] SETTLE_MS   = 13'h0104; // 260
	localparam logic [TW-1:0] RECOVER_MS  = 13'h02FD; // 765
	localparam logic [TW-1:0] HR_OFF_MS   = 13'h001E; // 30
	localparam logic [TW-1:0] DEBOUNCE_MS = 13'h00B9; // 185
	localparam logic [TW-1:0] TRANS_MS    = 13'h001E; // 30
	localparam logic [TW-1:0] FAULT_MS    = 13'h0573; // 1395
	localparam logic [TW-1:0] SHORT_MS    = 13'h03D9; // 985
	localparam logic [TW-1:0] ON_FAIL_MS  = 13'h0258; // 600
	localparam logic [TW-1:0] NORESP_MS   = 13'h12C0; // 4800

	// Microsecond response limits and their cycle budgets (round down)
	localparam int GD_OFF_US   = 5;
	localparam int FOVP_US     = 30;
	localparam int OCP_US      = 30;
	localparam int TJ_US       = 10;
	localparam int GD_OFF_CYC  = GD_OFF_US * CLK_MHZ;
	localparam int FOVP_CYC    = FOVP_US * CLK_MHZ;
	localparam int OCP_CYC     = OCP_US * CLK_MHZ;
	localparam int TJ_CYC      = TJ_US * CLK_MHZ;

	// Register map
	localparam logic [11:0] CTRL_ADDR   = 12'h000;
	localparam logic [11:0] STATUS_ADDR = 12'h004;
	localparam logic        CTRL_RESET  = 1'h1;
	localparam int          CTRL_EN_BIT = 0;

	// Synchronised pin vector positions
	localparam int SYNC_W  = 7;
	localparam int I_ATT   = 0;
	localparam int I_GDN   = 1;
	localparam int I_PWR   = 2;
	localparam int I_SHORT = 3;
	localparam int I_FOVP  = 4;
	localparam int I_OCP   = 5;
	localparam int I_TJ    = 6;

	typedef enum logic [3:0] {
		ST_IDLE,
		ST_DEBOUNCE,
		ST_RUN,
		ST_TRANS,
		ST_SETTLE,
		ST_HR_WAIT,
		ST_RECOVER,
		ST_RETRY
	} seq_state_e;

endpackage

/* File: core/pd_source_timing_sequencer.sv */
// Timing sequencer of a data-less USB PD / Type-C source controller.
// Assumes analog comparators and the PD protocol engine sit outside;
// protocol events arrive on pclk, comparator levels are asynchronous.
//
// Functional notes
// - Arm undervoltage and overcurrent protection 190 ms after gate on.
// - Send PS_RDY 260 ms after the supply selects change.
// - Hold gate off 765 ms of recovery after a hard reset.
// - Turn gate off 30 ms after transmitting a hard reset.
// - Debounce attach 185 ms before driving attach indicator low.
// - Change supply selects 30 ms after accepting a request.
// - Repeat hard reset every 1395 ms while a supply fault persists.
// - Retry with hard reset every 985 ms while VBUS stays shorted; the code waits 985 ms per short trip, then recovers and re-arms first.
// - Hard reset 600 ms after attach if supply cannot turn on.
// - Hard reset after 4.8 s without sink communication.
// - Enable logic supply output within 5 ms of attach.
// - Gate off within 5 us of gate-disable going low.
// - Gate off within 30 us of fast overvoltage.
// - Gate off within 30 us of a large overcurrent step.
// - Stop strong discharge within 10 us of thermal limit one.
// - Suppress slow OV/UV checks around voltage transitions.
// - Thermal limit one: hard reset, strong discharge off, bleed kept.
// - Advertise 3 A from gate on until first sink message, then 1.5 A.
//
// Local design decisions: the placing of the registers and the APB register port.
`timescale 1ns/1ns
module pd_source_timing_sequencer
	import pd_seq_pkg::*;
#(
	parameter int TICK_CYCLES = MS_CYCLES
)(
	// Clock and reset
	input  wire logic        pclk,
	input  wire logic        presetn,
	// APB slave
	input  wire logic [11:0] paddr,
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [31:0] pwdata,
	output logic [31:0]      prdata,
	output logic             pready,
	output logic             pslverr,
	// Asynchronous comparator and pin inputs
	input  wire logic        sink_attached,
	input  wire logic        gate_disable_n,
	input  wire logic        power_input,
	input  wire logic        vbus_short,
	input  wire logic        fast_overvoltage,
	input  wire logic        overcurrent_step,
	input  wire logic        thermal_limit_one,
	// Protocol engine events on pclk
	input  wire logic        msg_rx,
	input  wire logic        req_accept,
	input  wire logic [1:0]  req_sel,
	// Power path controls
	output logic             gate_drive_out,
	output logic             supply_select_a,
	output logic             supply_select_b,
	output logic             attach_indicator_n,
	output logic             logic_supply_out,
	output logic             overcurrent_protect,
	output logic             slow_overvoltage_check,
	output logic             slow_undervoltage_check,
	output logic             discharge_path,
	output logic             discharge_bleed,
	output logic             rp_level_3a,
	// Protocol engine requests
	output logic             hard_reset_tx,
	output logic             ps_rdy_tx
);

	function automatic logic reached(logic [TW-1:0] cnt, logic [TW-1:0] lim);
		reached = (cnt >= lim);
	endfunction

	function automatic logic gate_state(seq_state_e s);
		gate_state = (s == ST_RUN) || (s == ST_TRANS) || (s == ST_SETTLE);
	endfunction

	////////////////////////////////////////////////////////////////////////
	// Pin synchronisers: a change counts once stages two and three agree
	logic [SYNC_W-1:0] s1, s2, s3, flt;
	wire  [SYNC_W-1:0] pins = {thermal_limit_one, overcurrent_step,
		fast_overvoltage, vbus_short, power_input, gate_disable_n,
		sink_attached};

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			s1  <= '0;
			s2  <= '0;
			s3  <= '0;
			flt <= '0;
		end
		else
		begin
			s1  <= pins;
			s2  <= s1;
			s3  <= s2;
			flt <= (s2 & s3) | (flt & (s2 | s3));
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Register file
	logic enable;
	seq_state_e state, next_state;

	wire setup_ph  = psel & ~penable;
	wire sel_ctrl  = (paddr == CTRL_ADDR);
	wire sel_stat  = (paddr == STATUS_ADDR);
	wire wr_ctrl   = psel & penable & pready & pwrite & sel_ctrl;
	wire [31:0] rd_ctrl = {31'h0, enable};
	wire [31:0] rd_stat = {23'h0, flt[I_TJ], supply_select_b,
		supply_select_a, overcurrent_protect, gate_drive_out, state};
	wire [31:0] rd_data = sel_ctrl ? rd_ctrl : (sel_stat ? rd_stat : 32'h0);

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			pready  <= 1'b0;
			pslverr <= 1'b0;
			prdata  <= 32'h0;
			enable  <= CTRL_RESET;
		end
		else
		begin
			pready  <= setup_ph;
			pslverr <= setup_ph & ~(sel_ctrl | sel_stat);
			prdata  <= setup_ph ? rd_data : 32'h0;
			if (wr_ctrl)
				enable <= pwdata[CTRL_EN_BIT];
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Millisecond tick and interval counters
	logic [16:0]   tick_cnt;
	logic          ms_tick;
	logic [TW-1:0] ms_cnt, arm_cnt, nr_cnt, retry_ms, next_retry;
	logic          hr_req, ps_req;

	wire live       = flt[I_ATT] & enable;
	wire supply_ok  = flt[I_GDN] & flt[I_PWR];
	wire fast_trip  = gate_drive_out & (~flt[I_GDN] | flt[I_FOVP] |
		(overcurrent_protect & flt[I_OCP]));
	wire short_trip = gate_drive_out & overcurrent_protect & flt[I_SHORT];
	wire tj_trip    = gate_drive_out & flt[I_TJ];
	wire restart    = (next_state != state) | hr_req;
	wire next_gate  = gate_state(next_state) & flt[I_GDN] & ~fast_trip;
	wire next_arm   = next_gate & gate_drive_out & reached(arm_cnt, ARM_MS);
	wire next_chk   = next_arm & (next_state == ST_RUN);

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			tick_cnt <= '0;
			ms_tick  <= 1'b0;
		end
		else
		begin
			ms_tick  <= (tick_cnt == 17'(TICK_CYCLES - 1));
			tick_cnt <= (tick_cnt == 17'(TICK_CYCLES - 1)) ? '0 :
				tick_cnt + 17'h00001;
		end
	end

	// Each counter restarts on the event that opens its interval
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			ms_cnt  <= '0;
			arm_cnt <= '0;
			nr_cnt  <= '0;
		end
		else
		begin
			if (restart)
				ms_cnt <= '0;
			else if (ms_tick && ms_cnt != '1)
				ms_cnt <= ms_cnt + 13'h0001;
			if (!gate_drive_out)
				arm_cnt <= '0;
			else if (ms_tick && !reached(arm_cnt, ARM_MS))
				arm_cnt <= arm_cnt + 13'h0001;
			if (msg_rx || state != ST_RUN)
				nr_cnt <= '0;
			else if (ms_tick && nr_cnt != '1)
				nr_cnt <= nr_cnt + 13'h0001;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Sequencer
	always_comb
	begin
		next_state = state;
		next_retry = retry_ms;
		hr_req     = 1'b0;
		ps_req     = 1'b0;
		case (state)
			ST_IDLE:
				next_state = ST_DEBOUNCE;
			ST_DEBOUNCE:
				if (reached(ms_cnt, DEBOUNCE_MS))
				begin
					next_state = supply_ok ? ST_RUN : ST_RETRY;
					next_retry = ON_FAIL_MS;
				end
			ST_RUN:
				if (reached(nr_cnt, NORESP_MS))
				begin
					hr_req     = 1'b1;
					next_state = ST_HR_WAIT;
				end
				else if (req_accept)
					next_state = ST_TRANS;
			ST_TRANS:
				if (reached(ms_cnt, TRANS_MS))
					next_state = ST_SETTLE;
			ST_SETTLE:
				if (reached(ms_cnt, SETTLE_MS))
				begin
					ps_req     = 1'b1;
					next_state = ST_RUN;
				end
			ST_HR_WAIT:
				if (reached(ms_cnt, HR_OFF_MS))
					next_state = ST_RECOVER;
			ST_RECOVER:
				if (reached(ms_cnt, RECOVER_MS))
				begin
					next_state = supply_ok ? ST_RUN : ST_RETRY;
					next_retry = FAULT_MS;
				end
			ST_RETRY:
				if (reached(ms_cnt, retry_ms))
				begin
					hr_req     = 1'b1;
					next_retry = FAULT_MS;
					// A cleared fault gets the normal recovery path
					if (supply_ok)
						next_state = ST_HR_WAIT;
				end
			default:
				next_state = ST_IDLE;
		endcase
		// Shutdown outranks every sequencing step; only a detach or a cleared enable wins over it
		if (fast_trip || short_trip)
		begin
			hr_req     = 1'b0;
			ps_req     = 1'b0;
			next_state = ST_RETRY;
			next_retry = fast_trip ? FAULT_MS : SHORT_MS;
		end
		else if (tj_trip && state != ST_HR_WAIT)
		begin
			hr_req     = 1'b1;
			ps_req     = 1'b0;
			next_state = ST_HR_WAIT;
		end
		if (!live)
		begin
			hr_req     = 1'b0;
			ps_req     = 1'b0;
			next_state = ST_IDLE;
		end
	end

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			state    <= ST_IDLE;
			retry_ms <= FAULT_MS;
		end
		else
		begin
			state    <= next_state;
			retry_ms <= next_retry;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Output flops
	logic [1:0] req_hold;
	wire new_v  = (state == ST_TRANS) && (next_state == ST_SETTLE);
	wire safe_v = (next_state == ST_IDLE) || (next_state == ST_RECOVER);
	// HR_WAIT keeps the gate only if it was already on
	wire hold_g = (next_state == ST_HR_WAIT) & gate_drive_out & ~fast_trip;

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			req_hold                <= 2'h0;
			gate_drive_out          <= 1'b0;
			supply_select_a         <= 1'b0;
			supply_select_b         <= 1'b0;
			attach_indicator_n      <= 1'b1;
			logic_supply_out        <= 1'b0;
			overcurrent_protect     <= 1'b0;
			slow_overvoltage_check  <= 1'b0;
			slow_undervoltage_check <= 1'b0;
			discharge_path          <= 1'b0;
			discharge_bleed         <= 1'b1;
			rp_level_3a             <= 1'b0;
			hard_reset_tx           <= 1'b0;
			ps_rdy_tx               <= 1'b0;
		end
		else
		begin
			if (req_accept && state == ST_RUN)
				req_hold <= req_sel;
			gate_drive_out <= next_gate | hold_g;
			if (new_v)
				{supply_select_b, supply_select_a} <= req_hold;
			else if (safe_v)
				{supply_select_b, supply_select_a} <= 2'h0;
			attach_indicator_n <= (next_state == ST_IDLE) ||
				(next_state == ST_DEBOUNCE);
			logic_supply_out        <= (next_state != ST_IDLE);
			overcurrent_protect     <= next_arm;
			slow_overvoltage_check  <= next_chk;
			slow_undervoltage_check <= next_chk;
			discharge_path <= ~next_gate & ~hold_g & ~flt[I_TJ] &
				(next_state == ST_RECOVER);
			discharge_bleed <= ~(next_gate | hold_g);
			rp_level_3a <= next_gate & ~msg_rx &
				(~gate_drive_out | rp_level_3a);
			hard_reset_tx <= hr_req;
			ps_rdy_tx     <= ps_req;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Assertions
	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);

	sequence s_settle_end;
		$past(state) == ST_SETTLE ##0 $past(ms_cnt) == SETTLE_MS;
	endsequence

	a_arm_delay: assert property ($rose(overcurrent_protect) |->
		$past(arm_cnt) == ARM_MS && gate_drive_out)
		else $error("protection armed at wrong time");
	a_psrdy_settle: assert property (ps_rdy_tx |-> s_settle_end)
		else $error("PS_RDY before settling ended");
	a_recover_gate: assert property (state == ST_RECOVER &&
		$past(state) == ST_RECOVER |-> !gate_drive_out)
		else $error("gate on during recovery");
	a_hr_gate_off: assert property (state == ST_RECOVER &&
		$past(state) == ST_HR_WAIT |-> !gate_drive_out &&
		$past(ms_cnt) == HR_OFF_MS)
		else $error("gate off not 30 ms after hard reset");
	a_attach_deb: assert property ($fell(attach_indicator_n) |->
		$past(state) == ST_DEBOUNCE && $past(ms_cnt) == DEBOUNCE_MS)
		else $error("attach indicator not debounced");
	a_select_delay: assert property (state == ST_SETTLE &&
		$past(state) == ST_TRANS |-> $past(ms_cnt) == TRANS_MS)
		else $error("supply select changed early");
	a_retry_period: assert property (hard_reset_tx &&
		$past(state) == ST_RETRY |-> $past(ms_cnt) == $past(retry_ms))
		else $error("retry interval wrong");
	a_noresp_hr: assert property (hard_reset_tx && $past(state) == ST_RUN
		&& !$past(tj_trip) |-> $past(nr_cnt) == NORESP_MS)
		else $error("no-response retry wrong");
	a_logic_supply: assert property (!attach_indicator_n |->
		logic_supply_out)
		else $error("logic supply off while attached");
	a_fast_off: assert property (fast_trip |=>
		!gate_drive_out [*2])
		else $error("gate not shut down on fault");
	a_thermal_discharge_path: assert property (flt[I_TJ] |=>
		!discharge_path)
		else $error("discharge left on when hot");
	a_trans_checks: assert property ((state == ST_TRANS ||
		state == ST_SETTLE) |-> !slow_overvoltage_check &&
		!slow_undervoltage_check)
		else $error("slow checks active during transition");
	a_rp_drop: assert property (msg_rx |=> !rp_level_3a)
		else $error("3 A level kept after message");

endmodule // pd_source_timing_sequencer

/* File: testbench/pd_sink_model.sv */
// Behavioural USB PD sink seen through the protocol engine events.
// Assumes the bench commands attach, messages and requests on pclk.
`timescale 1ns/1ns
module pd_sink_model (
	// Clock
	input  wire logic       pclk,
	// Commands from the bench
	input  wire logic       attach,
	input  wire logic       talk,
	input  wire logic       ask,
	input  wire logic [1:0] ask_sel,
	// Events towards the device
	output logic            sink_attached = 1'h0,
	output logic            msg_rx        = 1'h0,
	output logic            req_accept    = 1'h0,
	output logic [1:0]      req_sel       = 2'h0
);
	always_ff @(posedge pclk)
	begin
		sink_attached <= attach;
		msg_rx        <= talk & attach;
		req_accept    <= ask & attach;
		// Code means nothing without the accept pulse, so it keeps moving
		req_sel       <= ask ? ask_sel : ~req_sel;
	end
endmodule // pd_sink_model

/* File: testbench/pd_source_timing_sequencer_tb.sv */
// Self-checking bench of the PD source timing sequencer.
// Assumes a short tick so the long intervals fit one run.
`timescale 1ns/1ns
module pd_source_timing_sequencer_tb;
	import pd_seq_pkg::*;
	localparam int T = 4;
	localparam int GT = 0, AT = 1, HR = 2, AR = 3, SA = 4, PS = 5, DP = 6;
	localparam int OV = 7, LS = 8;
	logic        pclk = 1'h0, presetn = 1'h0;
	logic [11:0] paddr = 12'h000;
	logic        psel = 1'h0, penable = 1'h0, pwrite = 1'h0;
	logic [31:0] pwdata = 32'h0, prdata, rd;
	logic        pready, pslverr, er;
	logic        gate_disable_n = 1'h1, power_input = 1'h1, vbus_short = 1'h0;
	logic        thermal_limit_one = 1'h0;
	logic        fast_overvoltage = 1'h0, overcurrent_step = 1'h0;
	logic        attach = 1'h0, talk = 1'h0, ask = 1'h0;
	logic [1:0]  ask_sel = 2'h0, req_sel;
	logic        sink_attached, msg_rx, req_accept;
	logic        gate_drive_out, supply_select_a, supply_select_b;
	logic        attach_indicator_n, logic_supply_out, overcurrent_protect;
	logic        slow_overvoltage_check, slow_undervoltage_check;
	logic        discharge_path, discharge_bleed, rp_level_3a;
	logic        hard_reset_tx, ps_rdy_tx;
	int          mismatches = 0, comparisons = 0, n, m;
	wire  [8:0]  obs = {logic_supply_out, slow_overvoltage_check,
		discharge_path, ps_rdy_tx, supply_select_a, overcurrent_protect,
		hard_reset_tx, attach_indicator_n, gate_drive_out};

	always #5 pclk = ~pclk;

	pd_source_timing_sequencer #(.TICK_CYCLES(T)) dut (.pclk(pclk),
		.presetn(presetn), .paddr(paddr), .psel(psel), .penable(penable),
		.pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .sink_attached(sink_attached),
		.gate_disable_n(gate_disable_n), .power_input(power_input),
		.vbus_short(vbus_short), .fast_overvoltage(fast_overvoltage),
		.overcurrent_step(overcurrent_step),
		.thermal_limit_one(thermal_limit_one),
		.msg_rx(msg_rx), .req_accept(req_accept), .req_sel(req_sel),
		.gate_drive_out(gate_drive_out), .supply_select_a(supply_select_a),
		.supply_select_b(supply_select_b),
		.attach_indicator_n(attach_indicator_n),
		.logic_supply_out(logic_supply_out),
		.overcurrent_protect(overcurrent_protect),
		.slow_overvoltage_check(slow_overvoltage_check),
		.slow_undervoltage_check(slow_undervoltage_check),
		.discharge_path(discharge_path), .discharge_bleed(discharge_bleed),
		.rp_level_3a(rp_level_3a), .hard_reset_tx(hard_reset_tx),
		.ps_rdy_tx(ps_rdy_tx));

	pd_sink_model sink (.pclk(pclk), .attach(attach), .talk(talk),
		.ask(ask), .ask_sel(ask_sel), .sink_attached(sink_attached),
		.msg_rx(msg_rx), .req_accept(req_accept), .req_sel(req_sel));

	////////////////////////////////////////////////////////////////////////
	task check(input logic [31:0] seen, input logic [31:0] exp);
		comparisons++;
		if (seen !== exp)
		begin
			mismatches++;
			$display("unexpected at %0t: seen %h expected %h", $time, seen,
				exp);
		end
	endtask

	// Tick counts may land one tick late plus the pin synchroniser delay
	task near(input int cnt, input int ticks);
		int e;
		e = ticks * T;
		check((cnt + 12 >= e && cnt <= e + T + 12) ? e : cnt, e);
	endtask

	task cyc(input int k);
		repeat (k) @(posedge pclk);
	endtask

	task wait_bit(input int idx, input logic v, output int cnt);
		cnt = 0;
		while (obs[idx] !== v && cnt < 40000)
		begin
			@(posedge pclk);
			cnt++;
		end
	endtask

	task pulse(input int which);
		if (which == 0) talk <= 1'h1; else ask <= 1'h1;
		@(posedge pclk);
		talk <= 1'h0;
		ask  <= 1'h0;
	endtask

	task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
		int k;
		psel    <= 1'h1;
		penable <= 1'h0;
		pwrite  <= w;
		paddr   <= a;
		pwdata  <= d;
		@(posedge pclk);
		penable <= 1'h1;
		k = 0;
		do
		begin
			@(posedge pclk);
			k++;
		end
		while (pready !== 1'h1 && k < 50);
		rd = prdata;
		er = pslverr;
		psel    <= 1'h0;
		penable <= 1'h0;
		// Idle edge so the next call never reassigns psel in this step
		@(posedge pclk);
	endtask

	task restart;
		apb(1'h1, CTRL_ADDR, 32'h0);
		apb(1'h1, CTRL_ADDR, 32'h1);
	endtask

	////////////////////////////////////////////////////////////////////////
	task t_regs;
		apb(1'h0, CTRL_ADDR, 32'h0);
		check(rd, 32'h00000001);
		check(er, 1'h0);
		apb(1'h1, STATUS_ADDR, 32'hFFFF_FFFF);
		apb(1'h0, STATUS_ADDR, 32'h0);
		check({er, rd[4:0]}, 6'h00);
		apb(1'h0, 12'h008, 32'h0);
		check(rd, 32'h00000000);
		check(er, 1'h1);
		check({attach_indicator_n, discharge_bleed, gate_drive_out}, 3'h6);
	endtask

	task t_attach;
		attach <= 1'h1;
		wait_bit(LS, 1'h1, n);
		check(n <= 5 * T, 1'h1);
		wait_bit(AT, 1'h0, m);
		near(n + m, 185);
		cyc(2);
		check({gate_drive_out, rp_level_3a}, 2'h3);
		wait_bit(AR, 1'h1, n);
		near(n + 2, 190);
		cyc(2);
		check({slow_overvoltage_check, slow_undervoltage_check}, 2'h3);
		pulse(0);
		cyc(4);
		check(rp_level_3a, 1'h0);
	endtask

	task t_request;
		ask_sel <= 2'h1;
		pulse(1);
		cyc(8);
		check({slow_overvoltage_check, slow_undervoltage_check}, 2'h0);
		wait_bit(SA, 1'h1, n);
		near(n + 8, 30);
		check(supply_select_b, 1'h0);
		wait_bit(PS, 1'h1, n);
		near(n, 260);
		wait_bit(OV, 1'h1, n);
		check(n <= 8, 1'h1);
	endtask

	task t_silent;
		pulse(0);
		wait_bit(HR, 1'h1, n);
		near(n, 4800);
		wait_bit(GT, 1'h0, n);
		near(n, 30);
		cyc(3);
		check({discharge_path, discharge_bleed}, 2'h3);
		thermal_limit_one <= 1'h1;
		wait_bit(DP, 1'h0, m);
		check(m <= 6, 1'h1);
		check(discharge_bleed, 1'h1);
		thermal_limit_one <= 1'h0;
		wait_bit(GT, 1'h1, n);
		near(n + m + 3, 765);
		cyc(4);
		thermal_limit_one <= 1'h1;
		wait_bit(HR, 1'h1, n);
		check(n <= 10, 1'h1);
		thermal_limit_one <= 1'h0;
	endtask

	task t_fault;
		restart;
		wait_bit(AT, 1'h0, n);
		cyc(4);
		gate_disable_n <= 1'h0;
		wait_bit(GT, 1'h0, n);
		check(n <= 6, 1'h1);
		wait_bit(HR, 1'h1, n);
		cyc(1);
		wait_bit(HR, 1'h1, n);
		near(n + 1, 1395);
		gate_disable_n <= 1'h1;
	endtask

	task t_no_supply;
		power_input <= 1'h0;
		restart;
		wait_bit(AT, 1'h0, n);
		wait_bit(HR, 1'h1, n);
		near(n, 600);
		check(gate_drive_out, 1'h0);
		power_input <= 1'h1;
	endtask

	task t_short;
		restart;
		wait_bit(AR, 1'h1, n);
		vbus_short <= 1'h1;
		wait_bit(GT, 1'h0, n);
		check(n <= 6, 1'h1);
		wait_bit(HR, 1'h1, m);
		near(n + m, 985);
		vbus_short <= 1'h0;
	endtask

	task t_fast;
		restart;
		wait_bit(AR, 1'h1, n);
		fast_overvoltage <= 1'h1;
		wait_bit(GT, 1'h0, n);
		check(n <= 6, 1'h1);
		fast_overvoltage <= 1'h0;
		restart;
		wait_bit(AR, 1'h1, n);
		overcurrent_step <= 1'h1;
		wait_bit(GT, 1'h0, n);
		check(n <= 6, 1'h1);
		overcurrent_step <= 1'h0;
	endtask

	task report_and_stop;
		if (mismatches == 0 && comparisons > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask

	////////////////////////////////////////////////////////////////////////
	initial
	begin
		cyc(3);
		presetn <= 1'h1;
		cyc(6);
		t_regs;
		t_attach;
		t_request;
		t_silent;
		t_fault;
		t_no_supply;
		t_short;
		t_fast;
		report_and_stop;
	end

	initial
	begin
		cyc(100000);
		mismatches++;
		report_and_stop;
	end
endmodule // pd_source_timing_sequencer_tb
